/* File: core/flash_self_program_control.sv */
// Flash self-programming controller with APB control register
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_control
  import self_prog_pkg::*;
#(
  parameter int WORD_BITS = 5, // Word-in-page address bits
  parameter int PAGE_BITS = 7, // Page index address bits
  parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 96 // First page of the no-rww section
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core instruction side
  input wire logic storeInstr,
  input wire logic loadInstr,
  input wire logic [15:0] zPointer,
  input wire logic [7:0] dataLowReg,
  input wire logic [7:0] dataHighReg,
  input wire logic globalIrqEn,
  input wire logic [7:0] fuseBits,
  output logic [7:0] loadData,
  output logic loadValid,
  output logic cpuStall,
  output logic rwwBlocked,
  output logic storeReadyIrq,
  // Flash array side
  input wire logic flashDone,
  input wire logic [WORD_BITS-1:0] bufReadIdx,
  output logic [15:0] bufReadData,
  output logic flashStart,
  output logic flashErase,
  output logic [PAGE_BITS-1:0] flashPage
);

  localparam int WORDS = 1 << WORD_BITS;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Page index from a byte pointer
  function automatic logic [PAGE_BITS-1:0] pageOf(input logic [15:0] z);
    pageOf = z[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  endfunction

  // Word index from a byte pointer, bit zero ignored
  function automatic logic [WORD_BITS-1:0] wordOf(input logic [15:0] z);
    wordOf = z[WORD_BITS:1];
  endfunction

  // Whether a page lies in the no-read-while-write section
  function automatic logic inNrww(input logic [PAGE_BITS-1:0] p);
    inNrww = (32'(p) >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic irqEnable_reg; // Ready interrupt enable
  logic rwwBusy_reg; // Section busy flag
  logic [4:0] cmd_reg; // Armed command bits, store enable at bit 0
  logic [2:0] window_reg; // Store window countdown
  logic [2:0] loadWin_reg; // Lock/fuse read window countdown
  op_state_e opState_reg; // Erase/write progress
  logic [7:0] lockBits_reg; // Boot lock bits
  logic [15:0] buffer [WORDS]; // Temporary page buffer
  logic [WORDS-1:0] bufValid_reg; // Buffer word already loaded

  // Decoded APB access
  logic apbAccess;
  logic apbWrite;
  logic ctrlHit;
  logic lockHit;
  logic [4:0] wrCmd;
  logic cmdAccept;
  logic opBusy;
  logic storeArmed;
  logic storeFire;
  logic windowExpire;

  assign apbAccess = psel && penable && !pready;
  assign apbWrite = apbAccess && pwrite;
  assign ctrlHit = (paddr == CTRL_OFFSET);
  assign lockHit = (paddr == LOCK_OFFSET);
  assign wrCmd = pwdata[4:0];
  assign opBusy = (opState_reg != OP_IDLE);
  assign storeArmed = cmd_reg[STORE_EN_BIT] && !opBusy;
  assign storeFire = storeInstr && storeArmed;
  assign windowExpire = storeArmed && !storeInstr && (window_reg == 3'h1);

  // Accept only the five codes, and nothing while an operation runs
  always_comb begin
    cmdAccept = 1'b0;
    if (apbWrite && ctrlHit && !opBusy) begin
      case (wrCmd)
        CMD_REENABLE, CMD_LOCK_SET, CMD_PAGE_WRITE,
        CMD_PAGE_ERASE, CMD_BUF_LOAD: cmdAccept = 1'b1;
        default: cmdAccept = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // APB slave: one wait state, registered answer
  // ****************************************************************

  // Answer strobe and error
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !ctrlHit && !lockHit;
    end
  end

  // Read data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (apbAccess) begin
      if (ctrlHit && !pwrite) begin
        // Reserved bit five stays zero
        prdata <= {24'h00_0000, irqEnable_reg, rwwBusy_reg, 1'b0, cmd_reg};
      end else if (lockHit && !pwrite) begin
        prdata <= {24'h00_0000, lockBits_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Interrupt enable bit is plain read/write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqEnable_reg <= CTRL_RESET[IRQ_EN_BIT];
    end else if (apbWrite && ctrlHit) begin
      irqEnable_reg <= pwdata[IRQ_EN_BIT];
    end
  end

  // ****************************************************************
  // Command bits and store window
  // ****************************************************************

  // Command bits: armed by write, cleared on store, expiry or finish
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= CTRL_RESET[4:0];
    end else if (cmdAccept) begin
      cmd_reg <= wrCmd;
    end else if (opState_reg == OP_RUN && flashDone) begin
      // Erase or write finished: store enable and op bit drop
      cmd_reg <= 5'h00;
    end else if (storeFire) begin
      if (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT]) begin
        // Store enable stays high through the operation
        cmd_reg <= cmd_reg;
      end else begin
        cmd_reg <= 5'h00;
      end
    end else if (windowExpire) begin
      // Nothing stored in time: every command bit clears together
      cmd_reg <= 5'h00;
    end
  end

  // Four-cycle store window, restarted on each accepted write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      window_reg <= 3'h0;
    end else if (cmdAccept) begin
      window_reg <= STORE_WINDOW;
    end else if (storeFire) begin
      window_reg <= 3'h0;
    end else if (window_reg != 3'h0) begin
      window_reg <= window_reg - 3'h1;
    end
  end

  // Three-cycle window for reading lock or fuse bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loadWin_reg <= 3'h0;
    end else if (cmdAccept && wrCmd == CMD_LOCK_SET) begin
      loadWin_reg <= LOAD_WINDOW;
    end else if (loadWin_reg != 3'h0) begin
      loadWin_reg <= loadWin_reg - 3'h1;
    end
  end

  // Lock or fuse read answer, pointer bit zero selects
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loadData <= 8'h00;
      loadValid <= 1'b0;
    end else begin
      loadValid <= loadInstr && (loadWin_reg != 3'h0);
      if (loadInstr && loadWin_reg != 3'h0) begin
        loadData <= zPointer[0] ? fuseBits : lockBits_reg;
      end
    end
  end

  // ****************************************************************
  // Boot lock bits
  // ****************************************************************

  // Lock bits only move toward programmed, from low data register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lockBits_reg <= LOCK_RESET;
    end else if (storeFire && cmd_reg[LOCK_SET_BIT]) begin
      lockBits_reg <= lockBits_reg & dataLowReg;
    end
  end

  // ****************************************************************
  // Erase and write sequencing
  // ****************************************************************

  // Operation state: start pulse, then wait for the array
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      opState_reg <= OP_IDLE;
    end else begin
      case (opState_reg)
        OP_IDLE: begin
          if (storeFire && (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT])) begin
            opState_reg <= OP_START;
          end
        end
        OP_START: opState_reg <= OP_RUN;
        OP_RUN: begin
          if (flashDone) begin
            opState_reg <= OP_IDLE;
          end
        end
        default: opState_reg <= OP_IDLE;
      endcase
    end
  end

  // Latch page and kind at start so the pointer is free afterwards
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flashPage <= '0;
      flashErase <= 1'b0;
    end else if (opState_reg == OP_IDLE && storeFire
                 && (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT])) begin
      flashPage <= pageOf(zPointer);
      flashErase <= cmd_reg[PAGE_ERASE_BIT];
    end
  end

  // One-cycle start strobe to the array
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flashStart <= 1'b0;
    end else begin
      flashStart <= (opState_reg == OP_IDLE) && storeFire
                    && (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT]);
    end
  end

  // Core stall for the whole no-rww operation
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpuStall <= 1'b0;
    end else if (opState_reg == OP_IDLE && storeFire
                 && (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT])) begin
      cpuStall <= inNrww(pageOf(zPointer));
    end else if (opState_reg == OP_RUN && flashDone) begin
      cpuStall <= 1'b0;
    end
  end

  // ****************************************************************
  // Section busy flag
  // ****************************************************************

  // Set by an rww operation, cleared by re-enable or buffer load
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rwwBusy_reg <= CTRL_RESET[RWW_BUSY_BIT];
    end else if (opState_reg == OP_IDLE && storeFire
                 && (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT])
                 && !inNrww(pageOf(zPointer))) begin
      rwwBusy_reg <= 1'b1;
    end else if (storeFire && cmd_reg[REENABLE_BIT]) begin
      rwwBusy_reg <= 1'b0;
    end else if (storeFire && cmd_reg == CMD_BUF_LOAD) begin
      rwwBusy_reg <= 1'b0;
    end
  end

  // Section access block seen by the fetch and load paths
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rwwBlocked <= 1'b0;
    end else begin
      // Up with the start strobe, down at the done edge unless the busy flag holds it
      rwwBlocked <= ((opState_reg == OP_IDLE) && storeFire
                     && (cmd_reg[PAGE_WRITE_BIT] || cmd_reg[PAGE_ERASE_BIT]))
                    || (opBusy && !(opState_reg == OP_RUN && flashDone))
                    || (rwwBusy_reg && !(storeFire && (cmd_reg[REENABLE_BIT]
                        || cmd_reg == CMD_BUF_LOAD)));
    end
  end

  // Ready interrupt held while enabled and store enable is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      storeReadyIrq <= 1'b0;
    end else begin
      storeReadyIrq <= irqEnable_reg && globalIrqEn && !cmd_reg[STORE_EN_BIT];
    end
  end

  // ****************************************************************
  // Temporary page buffer
  // ****************************************************************

  // Valid bits: a word is written once, then locked until cleared
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bufValid_reg <= '0;
    end else if (opState_reg == OP_RUN && flashDone && !flashErase) begin
      bufValid_reg <= '0;
    end else if (cmdAccept && wrCmd == CMD_REENABLE) begin
      // Re-enable written mid-load drops everything loaded so far
      bufValid_reg <= '0;
    end else if (storeFire && cmd_reg == CMD_BUF_LOAD) begin
      bufValid_reg[wordOf(zPointer)] <= 1'b1;
    end
  end

  // Buffer storage, written only into an empty slot
  always_ff @(posedge clk_sys) begin
    if (storeFire && cmd_reg == CMD_BUF_LOAD && !bufValid_reg[wordOf(zPointer)]) begin
      buffer[wordOf(zPointer)] <= {dataHighReg, dataLowReg};
    end
  end

  // Array read port, empty words read as erased
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bufReadData <= BUF_EMPTY;
    end else if (bufValid_reg[bufReadIdx]) begin
      bufReadData <= buffer[bufReadIdx];
    end else begin
      bufReadData <= BUF_EMPTY;
    end
  end

endmodule

`default_nettype wire

/* File: inc/self_prog_pkg.sv */
// Package: constants of the flash self-programming controller
package self_prog_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFSET = 12'h000; // Control register
  localparam logic [11:0] LOCK_OFFSET = 12'h004; // Boot lock readback

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int IRQ_EN_BIT = 7; // Ready interrupt enable
  localparam int RWW_BUSY_BIT = 6; // Section busy flag
  localparam int RSVD_BIT = 5; // Reserved, reads zero
  localparam int REENABLE_BIT = 4; // Section read re-enable
  localparam int LOCK_SET_BIT = 3; // Boot lock set
  localparam int PAGE_WRITE_BIT = 2; // Page write
  localparam int PAGE_ERASE_BIT = 1; // Page erase
  localparam int STORE_EN_BIT = 0; // Store enable

  // ****************************************************************
  // Accepted command codes (low five control bits)
  // ****************************************************************
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_LOCK_SET = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
  localparam logic [4:0] CMD_BUF_LOAD = 5'h01;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00; // Control register reset
  localparam logic [7:0] LOCK_RESET = 8'hFF; // Lock bits unprogrammed
  localparam logic [15:0] BUF_EMPTY = 16'hFFFF; // Unloaded buffer word
  localparam logic [2:0] STORE_WINDOW = 3'h4; // Cycles a command stays armed
  localparam logic [2:0] LOAD_WINDOW = 3'h3; // Cycles for lock/fuse read

  // Operation states
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_START,
    OP_RUN
  } op_state_e;

endpackage

/* File: verification/flash_array_model.sv */
// Flash array stand-in that answers each start pulse with a done pulse
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Controller side
  input wire logic flashStart,
  input wire logic [7:0] doneDelay,
  output logic flashDone
);
  logic [7:0] cntReg; // Cycles left in the running operation
  // Load the delay on start, pulse done when the count reaches one
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cntReg <= 8'h00;
      flashDone <= 1'b0;
    end else begin
      flashDone <= (cntReg == 8'h01);
      if (flashStart) begin
        cntReg <= doneDelay;
      end else if (cntReg != 8'h00) begin
        cntReg <= cntReg - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/flash_self_program_control_checker.sv */
// Port-level assertions for the self-programming controller
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_checker
  import self_prog_pkg::*;
#(
  parameter int PAGE_BITS = 7,
  parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 96
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and array side
  input wire logic loadInstr,
  input wire logic loadValid,
  input wire logic globalIrqEn,
  input wire logic storeReadyIrq,
  input wire logic cpuStall,
  input wire logic rwwBlocked,
  input wire logic flashStart,
  input wire logic [PAGE_BITS-1:0] flashPage
);
  import self_prog_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic taken; // First access cycle of a transfer
  assign taken = psel && penable && !pready;
  // ****
  // Assertions
  // ****
  apb_answer_a: assert property (taken |=> pready) else $error("no answer");
  answer_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (taken && paddr != CTRL_OFFSET && paddr != LOCK_OFFSET
    |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped accepted");
  reserved_zero_a: assert property (pready && !pwrite && paddr == CTRL_OFFSET
    |-> prdata[31:8] == 24'h00_0000 && !prdata[RSVD_BIT]) else $error("reserved bit set");
  irq_global_a: assert property (storeReadyIrq |-> $past(globalIrqEn))
    else $error("irq without global enable");
  load_answer_a: assert property (loadValid |-> $past(loadInstr))
    else $error("load answer uncaused");
  start_pulse_a: assert property (flashStart |=> !flashStart) else $error("start too long");
  stall_blocks_a: assert property (cpuStall |-> rwwBlocked)
    else $error("stall without block");
  stall_page_a: assert property ($rose(cpuStall) |-> flashPage >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
    else $error("stall on rww page");
  page_latched_a: assert property (flashStart |=> $stable(flashPage) [*2])
    else $error("page moved");
  // Main scenarios
  cover property (flashStart && cpuStall);
  cover property (flashStart && !cpuStall);
  cover property (loadValid);
  cover property (pslverr);
endmodule
bind flash_self_program_control flash_self_program_control_checker #(
  .PAGE_BITS(PAGE_BITS), .NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .loadInstr(loadInstr), .loadValid(loadValid), .globalIrqEn(globalIrqEn),
  .storeReadyIrq(storeReadyIrq), .cpuStall(cpuStall), .rwwBlocked(rwwBlocked),
  .flashStart(flashStart), .flashPage(flashPage));
`default_nettype wire

/* File: verification/tb_flash_self_program_control.sv */
// Self-checking bench for the self-programming controller
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_control;
  import self_prog_pkg::*;
  // ****
  // Signals and model state
  // ****
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, loadValid, cpuStall, rwwBlocked, storeReadyIrq;
  logic storeInstr = 1'b0, loadInstr = 1'b0, globalIrqEn = 1'b0, flashDone;
  logic [15:0] zPointer = 16'h0000, bufReadData;
  logic [7:0] dataLowReg = 8'h00, dataHighReg = 8'h00, fuseBits = 8'h5A, loadData;
  logic [7:0] doneDelay = 8'h1E;
  logic [4:0] bufReadIdx = 5'h00;
  logic flashStart, flashErase;
  logic [6:0] flashPage;
  logic [31:0] r;
  logic e;
  int nMismatch = 0, checkCount = 0, lockModel = 'hFF, n;
  int bufModel[32]; // Expected buffer words
  bit loaded[32]; // Words already written since the last clear
  logic [4:0] badCode[6] = '{5'h00, 5'h02, 5'h07, 5'h1F, 5'h13, 5'h0D};
  logic [4:0] goodCode[4] = '{CMD_BUF_LOAD, CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_LOCK_SET};
  // Clock at 100 ns period
  always #50 clk_sys = ~clk_sys;
  flash_self_program_control u_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .storeInstr(storeInstr), .loadInstr(loadInstr),
    .zPointer(zPointer), .dataLowReg(dataLowReg), .dataHighReg(dataHighReg),
    .globalIrqEn(globalIrqEn), .fuseBits(fuseBits), .loadData(loadData),
    .loadValid(loadValid), .cpuStall(cpuStall), .rwwBlocked(rwwBlocked),
    .storeReadyIrq(storeReadyIrq), .flashDone(flashDone), .bufReadIdx(bufReadIdx),
    .bufReadData(bufReadData), .flashStart(flashStart), .flashErase(flashErase),
    .flashPage(flashPage));
  flash_array_model u_flash (.clk_sys(clk_sys), .nrst(nrst), .flashStart(flashStart),
    .doneDelay(doneDelay), .flashDone(flashDone));
  // ****
  // Tasks
  // ****
  // Verdict and end of run
  task automatic printVerdict;
    if (nMismatch == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checkCount++;
    if (got !== ex) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Bounded wait ran out
  task automatic hang;
    nMismatch++;
    printVerdict();
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h0000_0000, x, y);
    chk(nm, ex, x);
  endtask
  // Command write followed by a store in the second window cycle
  task automatic cmd(input logic [7:0] c);
    wr(CTRL_OFFSET, {24'h00_0000, c});
    storeInstr <= 1'b1;
    @(posedge clk_sys);
    storeInstr <= 1'b0;
  endtask
  task automatic clearModel;
    for (int i = 0; i < 32; i++) begin
      bufModel[i] = 'hFFFF;
      loaded[i] = 1'b0;
    end
  endtask
  // Load one buffer word with random data and a random pointer bit zero
  task automatic load(input int w);
    logic [15:0] d;
    d = 16'($urandom);
    zPointer <= 16'((w << 1) | ($urandom & 1));
    {dataHighReg, dataLowReg} <= d;
    cmd({3'b000, CMD_BUF_LOAD});
    if (!loaded[w]) bufModel[w] = d;
    loaded[w] = 1'b1;
  endtask
  task automatic checkBuf;
    for (int i = 0; i < 32; i++) begin
      bufReadIdx <= 5'(i);
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk("buffer", bufModel[i], {16'h0000, bufReadData});
    end
  endtask
  // Page erase or write; pointer is scrambled right after the store
  task automatic op(input logic [4:0] c, input int pg);
    logic [31:0] busy;
    busy = (pg < 96) ? 32'h0000_0040 : 32'h0000_0000;
    zPointer <= 16'(pg << 6);
    cmd({3'b000, c});
    zPointer <= 16'($urandom);
    n = 0;
    while (flashStart !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) hang();
    chk("page", pg, {25'h0, flashPage});
    chk("erase", c == CMD_PAGE_ERASE, {31'h0, flashErase});
    chk("stall", pg >= 96, {31'h0, cpuStall});
    chk("blocked", 1, {31'h0, rwwBlocked});
    if (doneDelay > 8'h10) begin
      rdc("running", CTRL_OFFSET, busy | c);
      wr(CTRL_OFFSET, {27'h0, CMD_REENABLE});
      rdc("refused", CTRL_OFFSET, busy | c);
    end
    n = 0;
    do begin
      apb(1'b0, CTRL_OFFSET, 32'h0000_0000, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    if (n >= 50) hang();
    chk("done", busy, r);
    if (c == CMD_PAGE_WRITE) clearModel();
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(22468));
    clearModel();
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc("ctrlreset", CTRL_OFFSET, 32'h0000_0000);
    rdc("lockreset", LOCK_OFFSET, 32'h0000_00FF);
    apb(1'b0, 12'h008, 32'h0000_0000, r, e);
    chk("slverr", 1, {31'h0, e});
    chk("errdata", 0, r);
    checkBuf();
    globalIrqEn <= 1'b1;
    foreach (badCode[i]) begin
      wr(CTRL_OFFSET, {24'h0, 3'b100, badCode[i]});
      rdc("badcode", CTRL_OFFSET, 32'h0000_0080);
    end
    chk("irq", 1, {31'h0, storeReadyIrq});
    globalIrqEn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("irqoff", 0, {31'h0, storeReadyIrq});
    foreach (goodCode[i]) begin
      wr(CTRL_OFFSET, {27'h0, goodCode[i]});
      repeat (6) @(posedge clk_sys);
      rdc("expired", CTRL_OFFSET, 32'h0000_0000);
      storeInstr <= 1'b1;
      @(posedge clk_sys);
      storeInstr <= 1'b0;
      rdc("latestore", CTRL_OFFSET, 32'h0000_0000);
    end
    for (int i = 0; i < 6; i++) load($urandom_range(31));
    load(3);
    load(3);
    checkBuf();
    op(CMD_PAGE_ERASE, 10);
    load(7);
    rdc("loadclears", CTRL_OFFSET, 32'h0000_0000);
    op(CMD_PAGE_WRITE, 10);
    checkBuf();
    cmd({3'b000, CMD_REENABLE});
    rdc("reenable", CTRL_OFFSET, 32'h0000_0000);
    chk("unblocked", 0, {31'h0, rwwBlocked});
    doneDelay <= 8'h02;
    op(CMD_PAGE_ERASE, 100);
    load(5);
    wr(CTRL_OFFSET, {27'h0, CMD_REENABLE});
    clearModel();
    checkBuf();
    zPointer <= 16'h0001;
    wr(CTRL_OFFSET, {27'h0, CMD_LOCK_SET});
    loadInstr <= 1'b1;
    @(posedge clk_sys);
    loadInstr <= 1'b0;
    @(posedge clk_sys);
    chk("loadvalid", 1, {31'h0, loadValid});
    chk("fuse", fuseBits, {24'h0, loadData});
    dataLowReg <= 8'($urandom);
    @(posedge clk_sys);
    lockModel = lockModel & dataLowReg;
    cmd({3'b000, CMD_LOCK_SET});
    rdc("lockbits", LOCK_OFFSET, lockModel);
    rdc("lockclear", CTRL_OFFSET, 32'h0000_0000);
    // Pointer bit zero low reads the lock bits back
    zPointer <= 16'h0000;
    wr(CTRL_OFFSET, {27'h0, CMD_LOCK_SET});
    loadInstr <= 1'b1;
    @(posedge clk_sys);
    loadInstr <= 1'b0;
    @(posedge clk_sys);
    chk("lockread", lockModel, {24'h0, loadData});
    // Reset in mid-run empties the buffer and restores the lock bits
    load(9);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    clearModel();
    checkBuf();
    rdc("lockreset2", LOCK_OFFSET, 32'h0000_00FF);
    printVerdict();
  end
endmodule
`default_nettype wire
